// ==== prb_board_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - extended mode compares extended bits plus top four
// - word addressing over 15 or 19 lines
// - map enable lets control bit 9 unmap board
// - bits 0-3 write-protect blocks 0-3, reads work
// - polarity option picks protect-active level
// - reset protects all when active-low, none otherwise
// - unset polarity defaults to active-low
// - lower bound gives eight or four address msbs
// - upper bound gives eight or four address msbs
// - 16 control bits, base matched on a4-a11
// - zero to fifteen wait states per access
// - board protect switch overrides polarity and block bits
// - switch off leaves polarity and block bits
// - violation raises selected interrupt level when enabled
// - no level selected drives no interrupt line
// - access only inside inclusive bounds
// - switch on means address bit zero
// - four 4k-byte blocks, block 0 at lower bound
module prb_board_ctrl
	import prb_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [3:0] mem_xaddr,
	input wire logic [14:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata,
	output logic mem_ready,
	output logic mem_selected,
	input wire logic bit_wr,
	input wire logic bit_rd,
	input wire logic [11:0] bit_addr,
	input wire logic bit_wdata,
	output logic bit_rdata,
	input wire logic board_protect_switch,
	output logic [15:0] irq_lines
);
	logic [12:0] config_r, config_nxt;
	logic [15:0] bounds_r, bounds_nxt;
	logic [7:0] iobase_r, iobase_nxt;
	logic [15:0] control_r, control_nxt;
	logic viol_r, viol_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic bitrd_r, bitrd_nxt;
	prb_state_t state_r, state_nxt;
	logic [15:0] mrdata_r, mrdata_nxt;
	logic [15:0] ram [MEM_WORDS];
	logic ram_we;
	logic [12:0] ram_idx;
	logic [7:0] lo_key, hi_key, acc_key, blk_off;
	logic in_bounds, mapped, blk_prot, hit, bit_hit, viol_evt;
	logic [NUM_BLOCKS-1:0] prot;
	logic [1:0] blk;
	prb_wait_if wif ();

	// switch positions to bound key: on means bit zero, narrow mode uses four bits
	function automatic logic [7:0] bound_key(input logic [7:0] sw, input logic ext);
		logic [7:0] bits;
		bits = ~sw;
		bound_key = ext ? bits : {4'h0, bits[3:0]};
	endfunction

	// access key built at the width that the bound uses
	function automatic logic [7:0] addr_key(input logic [3:0] xa, input logic [3:0] top,
		input logic ext);
		addr_key = ext ? {xa, top} : {4'h0, top};
	endfunction

	// bound comparators and block selection
	always_comb begin
		lo_key = bound_key(bounds_r[7:0], config_r[CFG_LO_EXT]);
		hi_key = bound_key(bounds_r[15:8], config_r[CFG_HI_EXT]);
		acc_key = addr_key(mem_xaddr, mem_addr[14:11], config_r[CFG_LO_EXT]);
		in_bounds = (acc_key >= lo_key) &&
			(addr_key(mem_xaddr, mem_addr[14:11], config_r[CFG_HI_EXT]) <= hi_key);
		blk_off = acc_key - lo_key;
		blk = blk_off[1:0];
		mapped = !(config_r[CFG_MAP_EN] && control_r[CTL_MAP_BIT]);
		hit = in_bounds && mapped && (blk_off < 8'(NUM_BLOCKS));
		ram_idx = {blk, mem_addr[BLK_AW-1:0]};
	end

	// per-block protection
	always_comb begin
		for (int i = 0; i < NUM_BLOCKS; i++) begin
			prot[i] = board_protect_switch ||
				(config_r[CFG_POL] ? control_r[i] : !control_r[i]);
		end
		blk_prot = prot[blk];
	end

	// memory access sequencer
	always_comb begin
		state_nxt = state_r;
		mrdata_nxt = mrdata_r;
		wif.start = 1'b0;
		wif.count = config_r[CFG_WAIT_LSB +: 4];
		mem_ready = 1'b0;
		ram_we = 1'b0;
		viol_evt = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				if (mem_req && hit) begin
					wif.start = 1'b1;
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (wif.done) begin
					state_nxt = ST_ACK;
					if (mem_we) begin
						ram_we = !blk_prot;
						viol_evt = blk_prot;
					end else begin
						mrdata_nxt = ram[ram_idx];
					end
				end
			end
			ST_ACK: begin
				mem_ready = 1'b1;
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE; // the unused fourth code falls back to idle
			end
		endcase
	end

	prb_wait_gen u_wait (
		.clk(clk),
		.reset_n(reset_n),
		.w(wif.gen)
	);

	// ram storage, writes only when unprotected
	always_ff @(posedge clk) begin
		if (ram_we) begin
			ram[ram_idx] <= mem_wdata;
		end
	end

	// serial bit space decode: high eight bits against base, low four pick the bit
	always_comb begin
		bit_hit = (bit_addr[11:4] == iobase_r);
	end

	// register file, serial bit port and violation flag
	always_comb begin
		config_nxt = config_r;
		bounds_nxt = bounds_r;
		iobase_nxt = iobase_r;
		control_nxt = control_r;
		rdata_nxt = rdata_r;
		ack_nxt = 1'b0;
		bitrd_nxt = bitrd_r;
		viol_nxt = viol_r;
		if (bit_hit && bit_wr) begin
			control_nxt[bit_addr[3:0]] = bit_wdata;
		end
		if (bit_hit && bit_rd) begin
			bitrd_nxt = control_r[bit_addr[3:0]];
		end
		// take: latch the read word, waitrequest drops one cycle later
		if ((avs_read || avs_write) && !ack_r) begin
			ack_nxt = 1'b1;
			rdata_nxt = 32'h0000_0000;
			unique case (avs_address)
				REG_CONFIG: begin
					rdata_nxt[12:0] = config_r;
				end
				REG_BOUNDS: begin
					rdata_nxt[15:0] = bounds_r;
				end
				REG_IOBASE: begin
					rdata_nxt[7:0] = iobase_r;
				end
				REG_CONTROL: begin
					rdata_nxt[15:0] = control_r;
				end
				REG_STATUS: begin
					rdata_nxt[STA_MAPPED] = mapped;
					rdata_nxt[STA_PROT_LSB +: NUM_BLOCKS] = prot;
					rdata_nxt[STA_BOARD_WP] = board_protect_switch;
					rdata_nxt[STA_VIOL] = viol_r;
				end
				default: begin
					rdata_nxt = 32'h0000_0000;
				end
			endcase
		end
		// commit: a write lands only at the edge where waitrequest is seen low,
		// so a master that abandons the cycle early leaves no register changed
		if (avs_write && ack_r) begin
			unique case (avs_address)
				REG_CONFIG: begin
					config_nxt = avs_writedata[12:0];
				end
				REG_BOUNDS: begin
					bounds_nxt = avs_writedata[15:0];
				end
				REG_IOBASE: begin
					iobase_nxt = avs_writedata[7:0];
				end
				REG_CONTROL: begin
					control_nxt = avs_writedata[15:0]; // bus write wins over a serial bit
				end
				REG_STATUS: begin
					if (avs_writedata[STA_VIOL]) begin
						viol_nxt = 1'b0; // write one clears
					end
				end
				default: begin
					config_nxt = config_r; // unused offsets ignore writes
				end
			endcase
		end
		if (viol_evt) begin
			viol_nxt = 1'b1; // set wins over clear
		end
	end

	// bus handshake and interrupt drive
	always_comb begin
		avs_waitrequest = (avs_read || avs_write) && !ack_r;
		avs_readdata = rdata_r;
		mem_rdata = mrdata_r;
		bit_rdata = bitrd_r;
		mem_selected = mem_req && hit;
		irq_lines = 16'h0000;
		if (viol_r && config_r[CFG_IRQ_EN] && (config_r[CFG_IRQ_LSB +: 4] != 4'h0)) begin
			irq_lines[config_r[CFG_IRQ_LSB +: 4]] = 1'b1;
		end
	end

	// state registers; reset leaves control bits zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			config_r <= CONFIG_RST;
			bounds_r <= BOUNDS_RST;
			iobase_r <= IOBASE_RST;
			control_r <= CONTROL_RST;
			viol_r <= 1'b0;
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			bitrd_r <= 1'b0;
			state_r <= ST_IDLE;
			mrdata_r <= 16'h0000;
		end else begin
			config_r <= config_nxt;
			bounds_r <= bounds_nxt;
			iobase_r <= iobase_nxt;
			control_r <= control_nxt;
			viol_r <= viol_nxt;
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			bitrd_r <= bitrd_nxt;
			state_r <= state_nxt;
			mrdata_r <= mrdata_nxt;
		end
	end
endmodule // prb_board_ctrl
`default_nettype wire

// ==== prb_board_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module prb_asserts (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic mem_req,
	input wire logic mem_ready,
	input wire logic mem_selected,
	input wire logic [15:0] irq_lines
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// two idle cycles before any answer
	sequence s_quiet2;
		!mem_ready ##1 !mem_ready;
	endsequence
	a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("register answer late");
	a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest without request");
	a_ready_pulse: assert property (mem_ready |=> !mem_ready)
		else $error("ready longer than one cycle");
	a_ready_not_early: assert property ($rose(mem_req) |-> s_quiet2)
		else $error("ready too early");
	a_ready_bounded: assert property ($rose(mem_req) && mem_selected |-> ##[2:17] mem_ready)
		else $error("ready beyond fifteen waits");
	a_ready_needs_hit: assert property (mem_ready |-> mem_req && mem_selected)
		else $error("ready outside bounds");
	a_irq_one_level: assert property ($onehot0(irq_lines))
		else $error("more than one level");
	a_hit_held: assert property ($rose(mem_req) && !mem_selected |-> !mem_ready[*3])
		else $error("miss answered");
endmodule // prb_asserts
bind prb_board_ctrl prb_asserts u_chk (.clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest,
	.mem_req, .mem_ready, .mem_selected, .irq_lines);
`default_nettype wire

// ==== prb_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module prb_host_model (
	input wire logic clk,
	input wire logic mem_ready,
	input wire logic [15:0] mem_rdata,
	output logic mem_req,
	output logic mem_we,
	output logic [3:0] mem_xaddr,
	output logic [14:0] mem_addr,
	output logic [15:0] mem_wdata
);
	initial {mem_req, mem_we, mem_xaddr, mem_addr, mem_wdata} = '0;
	// extended address lines, changed only between accesses
	task automatic set_xaddr(input logic [3:0] x);
		@(posedge clk);
		mem_xaddr <= x;
	endtask
	// word access held until ready; cyc is -1 when nobody answers
	task automatic access(input logic we, input logic [14:0] a, input logic [15:0] d,
		output logic [15:0] q, output int cyc);
		cyc = -1;
		@(posedge clk);
		mem_req <= 1'b1;
		mem_we <= we;
		mem_addr <= a;
		mem_wdata <= d;
		for (int i = 0; i < 40 && cyc < 0; i++) begin
			@(posedge clk);
			if (mem_ready === 1'b1)
				cyc = i;
		end
		q = mem_rdata;
		mem_req <= 1'b0;
		mem_addr <= ~a; // released lines do not keep their value
		mem_wdata <= ~d;
	endtask
endmodule // prb_host_model
`default_nettype wire

// ==== prb_pkg.sv ====
package prb_pkg;
	// avalon register byte offsets
	localparam logic [4:0] REG_CONFIG = 5'h00;
	localparam logic [4:0] REG_BOUNDS = 5'h04;
	localparam logic [4:0] REG_IOBASE = 5'h08;
	localparam logic [4:0] REG_CONTROL = 5'h0c;
	localparam logic [4:0] REG_STATUS = 5'h10;
	// config field positions
	localparam int CFG_LO_EXT = 0;
	localparam int CFG_HI_EXT = 1;
	localparam int CFG_MAP_EN = 2;
	localparam int CFG_POL = 3;
	localparam int CFG_WAIT_LSB = 4;
	localparam int CFG_IRQ_LSB = 8;
	localparam int CFG_IRQ_EN = 12;
	// status field positions
	localparam int STA_MAPPED = 0;
	localparam int STA_PROT_LSB = 1;
	localparam int STA_BOARD_WP = 5;
	localparam int STA_VIOL = 6;
	// control bit positions
	localparam int CTL_MAP_BIT = 9;
	localparam int NUM_BLOCKS = 4;
	// reset values
	localparam logic [12:0] CONFIG_RST = 13'h0000;
	localparam logic [15:0] BOUNDS_RST = 16'h0000;
	localparam logic [7:0] IOBASE_RST = 8'h00;
	localparam logic [15:0] CONTROL_RST = 16'h0000;
	// memory geometry: 2k words (4 k bytes) per block
	localparam int BLK_AW = 11;
	localparam int MEM_WORDS = 8192;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACK} prb_state_t;
endpackage

// ==== prb_wait_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module prb_wait_gen
	import prb_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	prb_wait_if.gen w
);
	logic [3:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;

	// counts the selected wait states, done pulses when they are spent
	always_comb begin
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		w.done = 1'b0;
		if (w.start) begin
			cnt_nxt = w.count;
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			if (cnt_r == 4'h0) begin
				w.done = 1'b1;
				busy_nxt = 1'b0;
			end else begin
				cnt_nxt = cnt_r - 4'h1;
			end
		end
	end

	// register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 4'h0;
			busy_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
		end
	end
endmodule // prb_wait_gen
`default_nettype wire

// ==== prb_wait_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface prb_wait_if;
	logic start;
	logic [3:0] count;
	logic done;
	modport ctrl (output start, output count, input done);
	modport gen (input start, input count, output done);
endinterface
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import prb_pkg::*;
	logic clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, bit_wr = 0, bit_wdata = 0, sw = 0;
	logic bit_rd = 0, mem_selected, bit_rdata;
	logic [4:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata, r;
	logic avs_waitrequest, mem_req, mem_we, mem_ready;
	logic [3:0] mem_xaddr;
	logic [14:0] mem_addr;
	logic [15:0] mem_wdata, mem_rdata, irq_lines, q;
	logic [11:0] bit_addr = '0;
	int mismatches = 0, compares = 0, cyc, sel_cycles = 0;
	always #12.5 clk = ~clk;
	prb_board_ctrl dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .mem_req, .mem_we, .mem_xaddr, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ready, .mem_selected, .bit_wr, .bit_rd, .bit_addr, .bit_wdata,
		.bit_rdata, .board_protect_switch(sw), .irq_lines);
	// cycles in which the board claims the bus, counted at each edge
	always @(posedge clk) begin
		if (mem_selected === 1'b1) begin
			sel_cycles <= sel_cycles + 1;
		end
	end
	prb_host_model host (.clk, .mem_ready, .mem_rdata, .mem_req, .mem_we, .mem_xaddr, .mem_addr,
		.mem_wdata);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	// register cycle held until waitrequest is seen low
	task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 20) begin
			mismatches++;
			tally_and_finish();
		end
	endtask
	task automatic bw(input logic [7:0] base, input logic [3:0] b, input logic v);
		@(posedge clk);
		bit_wr <= 1'b1;
		bit_addr <= {base, b};
		bit_wdata <= v;
		@(posedge clk);
		bit_wr <= 1'b0;
	endtask
	// serial bit read, value stands one edge after the strobe
	task automatic br(input logic [7:0] base, input logic [3:0] b, input logic e);
		@(posedge clk);
		bit_rd <= 1'b1;
		bit_addr <= {base, b};
		@(posedge clk);
		bit_rd <= 1'b0;
		@(posedge clk);
		chk("serial bit", e, bit_rdata);
	endtask
	task automatic t_reset();
		av(0, REG_CONTROL, 0);
		chk("control", 0, r);
		av(0, REG_STATUS, 0);
		chk("blocks protected", 32'h1e, r & 32'h7e);
		av(0, 5'h14, 0);
		chk("unmapped", 0, r);
	endtask
	// both widths set alike, three waits, level five
	task automatic t_protect();
		av(1, REG_CONFIG, 32'h1530);
		av(1, REG_BOUNDS, 32'hfdfe);
		av(1, REG_IOBASE, 32'h3c);
		av(1, REG_CONTROL, 32'hf);
		av(0, REG_BOUNDS, 0);
		chk("bounds readback", 32'hfdfe, r);
		host.access(1, 15'h0800, 16'h1234, q, cyc);
		chk("wait cycles", 5, cyc);
		bw(8'h00, 0, 0);
		host.access(1, 15'h0800, 16'ha5a5, q, cyc);
		chk("open write", 5, cyc);
		bw(8'h3c, 0, 0);
		br(8'h3c, 0, 0);
		br(8'h3c, 1, 1);
		host.access(1, 15'h0800, 16'h5a5a, q, cyc);
		chk("protected write", 5, cyc);
		host.access(0, 15'h0800, 0, q, cyc);
		chk("protected read", 16'ha5a5, q);
		chk("irq", 16'h0020, irq_lines);
		av(1, REG_STATUS, 32'h40);
		@(posedge clk);
		chk("irq cleared", 0, irq_lines);
	endtask
	task automatic t_polarity();
		av(1, REG_CONFIG, 32'h1008);
		av(1, REG_CONTROL, 0);
		host.access(1, 15'h0800, 16'h5a5a, q, cyc);
		sw <= 1'b1;
		host.access(1, 15'h0800, 0, q, cyc);
		host.access(0, 15'h0800, 0, q, cyc);
		chk("switch protects", 16'h5a5a, q);
		chk("no level", 0, irq_lines);
		sw <= 1'b0;
	endtask
	task automatic t_map();
		host.access(0, 15'h1800, 0, q, cyc);
		chk("above bound", -1, cyc);
		host.access(0, 15'h1000, 0, q, cyc);
		chk("block one", 2, cyc);
		av(1, REG_CONTROL, 32'h200);
		host.access(0, 15'h1000, 0, q, cyc);
		chk("map ignored", 2, cyc);
		av(1, REG_CONFIG, 32'h4);
		host.access(0, 15'h1000, 0, q, cyc);
		chk("removed", -1, cyc);
	endtask
	// extended keys: xa joins each bound compare whose width is extended
	task automatic t_ext();
		int s;
		av(1, REG_CONTROL, 32'hf);
		av(1, REG_CONFIG, 32'h3);
		av(1, REG_BOUNDS, 32'hdede);
		host.set_xaddr(4'h2);
		s = sel_cycles;
		host.access(0, 15'h0800, 0, q, cyc);
		@(posedge clk);
		chk("extended hit", 2, cyc);
		chk("selected cycles", 3, sel_cycles - s);
		host.set_xaddr(4'h3);
		host.access(0, 15'h0800, 0, q, cyc);
		chk("extended miss", -1, cyc);
		av(1, REG_CONFIG, 32'h0);
		host.access(0, 15'h0800, 0, q, cyc);
		chk("narrow ignores xa", 2, cyc);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_protect();
		t_polarity();
		t_map();
		t_ext();
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
